// ==== verilog/nmi_reset_consts.vh ====
// Contract
// R1: Pin NMI sets NMI source bit 1
// R2: Watchdog NMI sets NMI source bit 0
// R3: Reading NMI source returns then clears both
// R4: CPU reset request sets reset cause bit 4
// R5: Watchdog reset sets reset cause bit 2
// R6: Reset pin sets reset cause bit 0
// R7: Writing zero clears a reset cause flag
// R8: Cause bits 3,1 undefined; software writes zero
// R9: Pin reset initializes; pin flag one, others zero
// R10: Unused upper bits always read zero
// R11: Flags stay set until their clearing action
`ifndef NMI_RESET_CONSTS_VH
`define NMI_RESET_CONSTS_VH
// Register byte offsets
`define OFF_NMI_SOURCE 8'h00
`define OFF_RESET_CAUSE 8'h04
`define OFF_IRQ_STATUS 8'h08
`define OFF_IRQ_MASK 8'h0C
// NMI source register fields
`define NMI_WDT_BIT 0
`define NMI_PIN_BIT 1
`define NMI_RESET_VAL 2'h0
// Reset cause register fields
`define RST_PIN_BIT 0
`define RST_RSVD1_BIT 1
`define RST_WDT_BIT 2
`define RST_RSVD3_BIT 3
`define RST_CPU_BIT 4
// Stored cause bits {cpu, wdt, pin} after a pin reset
`define RST_RESET_VAL 3'h1
// Interrupt status and mask fields
`define IRQ_NMI_WDT_BIT 0
`define IRQ_NMI_PIN_BIT 1
`define IRQ_RST_WDT_BIT 2
`define IRQ_RST_CPU_BIT 3
`define IRQ_RESET_VAL 4'h0
`define MASK_RESET_VAL 4'h0
`endif

// ==== verilog/sync_two_flop.v ====
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop
#(
	parameter WIDTH = 1
)
(
	input wire core_clk, // System clock
	input wire rst_n, // Asynchronous reset, active low
	input wire clkEn, // Clock enable
	input wire [WIDTH-1:0] asyncIn, // Signal from outside the clock domain
	output wire [WIDTH-1:0] syncOut // Synchronised signal
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end
		else if (clkEn)
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ==== verilog/sticky_flag_bank.v ====
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank
#(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
	input wire core_clk, // System clock
	input wire rst_n, // Asynchronous reset, active low
	input wire clkEn, // Clock enable
	input wire [WIDTH-1:0] setMask, // One-cycle set per bit
	input wire [WIDTH-1:0] clearMask, // One-cycle clear per bit
	output wire [WIDTH-1:0] flags // Current flag values
);
	reg [WIDTH-1:0] flags_reg;
	wire [WIDTH-1:0] flags_next;

	// A set arriving with its clear wins
	assign flags_next = (flags_reg & ~clearMask) | setMask; // R11

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_reg <= RESET_VAL;
		end
		else if (clkEn)
		begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;
endmodule
`default_nettype wire

// ==== verilog/nmi_and_reset_cause_flags.v ====
`timescale 1ns/1ps
`default_nettype none
`include "nmi_reset_consts.vh"
module nmi_and_reset_cause_flags
#(
	parameter ADR_WIDTH = 8
)
(
	input wire core_clk, // System clock, 50 MHz
	input wire rst_n, // Reset pin, asynchronous, active low
	input wire clkEn, // Clock enable, freezes all state when low
	input wire wbCyc, // Wishbone cycle
	input wire wbStb, // Wishbone strobe
	input wire wbWe, // Wishbone write enable
	input wire [ADR_WIDTH-1:0] wbAdr, // Wishbone byte address
	input wire [3:0] wbSel, // Wishbone byte selects
	input wire [31:0] wbDatIn, // Wishbone write data
	output wire [31:0] wbDatOut, // Wishbone read data
	output wire wbAck, // Wishbone acknowledge
	input wire nmiPin, // External NMI pin, asynchronous, active high
	input wire wdtNmiReq, // Watchdog NMI request, one-cycle pulse
	input wire wdtResetReq, // Watchdog reset request, one-cycle pulse
	input wire cpuSysResetReq, // CPU system reset request, one-cycle pulse
	output wire nmiRequest, // One-cycle pulse towards the CPU on any NMI
	output wire [1:0] nmiSourceFlags, // Current NMI source flags
	output wire [4:0] resetCauseFlags, // Current reset cause register image
	output wire irq // Level interrupt, unmasked status set
);
	localparam [ADR_WIDTH-1:0] ADR_NMI = `OFF_NMI_SOURCE;
	localparam [ADR_WIDTH-1:0] ADR_RST = `OFF_RESET_CAUSE;
	localparam [ADR_WIDTH-1:0] ADR_STAT = `OFF_IRQ_STATUS;
	localparam [ADR_WIDTH-1:0] ADR_MASK = `OFF_IRQ_MASK;

	// Bus answer states
	localparam [0:0] BUS_IDLE = 1'b0;
	localparam [0:0] BUS_ANSWER = 1'b1;

	reg busState_reg;
	reg busState_next;
	reg [31:0] rdData_reg;
	reg [31:0] rdData_next;
	reg [3:0] irqMask_reg;
	reg maskWrite;
	reg irq_reg;
	reg nmiPinDly_reg;
	reg nmiRequest_reg;

	wire busReq;
	wire rdAccess;
	wire wrAccess;
	wire hitNmi;
	wire hitRst;
	wire hitStat;
	wire hitMask;
	wire nmiPinSynced;
	wire nmiPinRise;
	reg [1:0] nmiSet;
	wire [1:0] nmiClear;
	wire [1:0] nmiFlags;
	reg [2:0] rstSet;
	reg [2:0] rstClear;
	wire [2:0] rstFlags;
	wire [4:0] rstImage;
	reg [3:0] irqSet;
	reg [3:0] irqClear;
	wire [3:0] irqStatus;
	wire irqLevel;

	// Bus access: taken at each edge where a request is seen in the idle state
	assign busReq = wbCyc & wbStb & (busState_reg == BUS_IDLE);
	assign rdAccess = busReq & ~wbWe;
	assign wrAccess = busReq & wbWe & wbSel[0];

	assign hitNmi = (wbAdr == ADR_NMI);
	assign hitRst = (wbAdr == ADR_RST);
	assign hitStat = (wbAdr == ADR_STAT);
	assign hitMask = (wbAdr == ADR_MASK);

	// NMI pin synchroniser and rising edge detect
	sync_two_flop
	#(
		.WIDTH(1)
	)
	nmiPinSync
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.asyncIn(nmiPin),
		.syncOut(nmiPinSynced)
	);

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmiPinDly_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			nmiPinDly_reg <= nmiPinSynced;
		end
	end

	assign nmiPinRise = nmiPinSynced & ~nmiPinDly_reg;

	// Each source event sets its cause flag and its interrupt status bit
	always @*
	begin
		nmiSet = 2'h0;
		// The pin flag is never set here; only rst_n sets it
		rstSet = 3'h0; // R6
		irqSet = 4'h0;

		if (nmiPinRise)
		begin
			nmiSet[`NMI_PIN_BIT] = 1'b1; // R1
			irqSet[`IRQ_NMI_PIN_BIT] = 1'b1;
		end
		if (wdtNmiReq)
		begin
			nmiSet[`NMI_WDT_BIT] = 1'b1; // R2
			irqSet[`IRQ_NMI_WDT_BIT] = 1'b1;
		end
		if (wdtResetReq)
		begin
			rstSet[1] = 1'b1; // R5
			irqSet[`IRQ_RST_WDT_BIT] = 1'b1;
		end
		if (cpuSysResetReq)
		begin
			rstSet[2] = 1'b1; // R4
			irqSet[`IRQ_RST_CPU_BIT] = 1'b1;
		end
	end

	// NMI source flags
	// Read returns the flags captured at this edge, then both clear; a flag set again in the same cycle stays set
	assign nmiClear = (rdAccess & hitNmi) ? 2'h3 : 2'h0; // R3

	sticky_flag_bank
	#(
		.WIDTH(2),
		.RESET_VAL(`NMI_RESET_VAL)
	)
	nmiFlagBank
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.setMask(nmiSet),
		.clearMask(nmiClear),
		.flags(nmiFlags)
	);

	// Reset cause flags, stored as {cpu, wdt, pin}
	// Write decode: a written zero clears a cause flag, a written one leaves it
	always @*
	begin
		rstClear = 3'h0;
		irqClear = 4'h0;
		maskWrite = 1'b0;

		if (wrAccess & hitRst)
		begin
			rstClear[2] = ~wbDatIn[`RST_CPU_BIT]; // R7
			rstClear[1] = ~wbDatIn[`RST_WDT_BIT]; // R7
			rstClear[0] = ~wbDatIn[`RST_PIN_BIT]; // R7
		end
		if (wrAccess & hitStat)
		begin
			irqClear = wbDatIn[3:0];
		end
		if (wrAccess & hitMask)
		begin
			maskWrite = 1'b1;
		end
	end

	// Reset pin initializes: pin flag one, cpu and wdt flags zero
	sticky_flag_bank
	#(
		.WIDTH(3),
		.RESET_VAL(`RST_RESET_VAL)
	)
	rstFlagBank
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.setMask(rstSet),
		.clearMask(rstClear),
		.flags(rstFlags)
	); // R9

	// Undefined positions are not stored and read as zero
	assign rstImage[`RST_CPU_BIT] = rstFlags[2];
	assign rstImage[`RST_RSVD3_BIT] = 1'b0; // R8
	assign rstImage[`RST_WDT_BIT] = rstFlags[1];
	assign rstImage[`RST_RSVD1_BIT] = 1'b0; // R8
	assign rstImage[`RST_PIN_BIT] = rstFlags[0];

	// Interrupt status: one sticky bit per source event, write one to clear

	sticky_flag_bank
	#(
		.WIDTH(4),
		.RESET_VAL(`IRQ_RESET_VAL)
	)
	irqFlagBank
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.setMask(irqSet),
		.clearMask(irqClear),
		.flags(irqStatus)
	);

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqMask_reg <= `MASK_RESET_VAL;
		end
		else if (clkEn)
		begin
			if (maskWrite)
			begin
				irqMask_reg <= wbDatIn[3:0];
			end
		end
	end

	assign irqLevel = |(irqStatus & irqMask_reg);

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			irq_reg <= irqLevel;
		end
	end

	// NMI notice to the CPU, one pulse for each cycle with an NMI source event
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmiRequest_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			nmiRequest_reg <= |nmiSet;
		end
	end

	// Read multiplexer; unused upper bits and unmapped offsets give zero
	always @*
	begin
		rdData_next = 32'h00000000;
		case (wbAdr)
			ADR_NMI:
			begin
				rdData_next[1:0] = nmiFlags; // R10
			end
			ADR_RST:
			begin
				rdData_next[4:0] = rstImage; // R10
			end
			ADR_STAT:
			begin
				rdData_next[3:0] = irqStatus;
			end
			ADR_MASK:
			begin
				rdData_next[3:0] = irqMask_reg;
			end
			default:
			begin
				rdData_next = 32'h00000000;
			end
		endcase
	end

	// Bus answer: one acknowledge cycle per request taken in idle;
	// a request still standing after its ack waits for the next idle cycle
	always @*
	begin
		busState_next = busState_reg;
		case (busState_reg)
			BUS_IDLE:
			begin
				if (busReq)
				begin
					busState_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER:
			begin
				busState_next = BUS_IDLE;
			end
			default:
			begin
				busState_next = BUS_IDLE;
			end
		endcase
	end

	// Wishbone answer: ack one cycle after the request, dropped after one cycle
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busState_reg <= BUS_IDLE;
			rdData_reg <= 32'h00000000;
		end
		else if (clkEn)
		begin
			busState_reg <= busState_next;
			if (rdAccess)
			begin
				rdData_reg <= rdData_next; // R3
			end
			else if (busReq)
			begin
				rdData_reg <= 32'h00000000;
			end
		end
	end

	assign wbAck = (busState_reg == BUS_ANSWER);
	assign wbDatOut = rdData_reg;
	assign irq = irq_reg;
	assign nmiRequest = nmiRequest_reg;
	assign nmiSourceFlags = nmiFlags;
	assign resetCauseFlags = rstImage;
endmodule
`default_nettype wire

// ==== tb/event_sources.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_sources
(
	input wire logic core_clk, // Clock
	output logic nmiPin, // NMI pin
	output logic wdtNmiReq, // Watchdog NMI
	output logic wdtResetReq, // Watchdog reset
	output logic cpuSysResetReq // CPU reset request
);
	initial
	begin
		nmiPin = 1'b0;
		wdtNmiReq = 1'b0;
		wdtResetReq = 1'b0;
		cpuSysResetReq = 1'b0;
	end
	// One-cycle pulse: 0 watchdog NMI, 1 watchdog reset, 2 CPU reset
	task automatic fire(input int kind);
		@(posedge core_clk);
		wdtNmiReq <= (kind == 0);
		wdtResetReq <= (kind == 1);
		cpuSysResetReq <= (kind == 2);
		@(posedge core_clk);
		wdtNmiReq <= 1'b0;
		wdtResetReq <= 1'b0;
		cpuSysResetReq <= 1'b0;
	endtask
	task automatic pin(input logic level);
		@(posedge core_clk);
		nmiPin <= level;
	endtask
endmodule
`default_nettype wire

// ==== tb/flags_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module flags_monitor
#(
	parameter ADR_WIDTH = 8
)
(
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic clkEn, // Enable
	input wire logic wbCyc, // Cycle
	input wire logic wbStb, // Strobe
	input wire logic wbWe, // Write
	input wire logic [ADR_WIDTH-1:0] wbAdr, // Address
	input wire logic [3:0] wbSel, // Selects
	input wire logic [31:0] wbDatIn, // Write data
	input wire logic [31:0] wbDatOut, // Read data
	input wire logic wbAck, // Ack
	input wire logic wdtNmiReq, // Watchdog NMI
	input wire logic wdtResetReq, // Watchdog reset
	input wire logic cpuSysResetReq, // CPU reset
	input wire logic nmiRequest, // NMI pulse
	input wire logic [1:0] nmiSourceFlags, // NMI flags
	input wire logic [4:0] resetCauseFlags // Cause flags
);
	wire take = clkEn && wbCyc && wbStb && !wbAck;
	wire rdNmi = take && !wbWe && wbAdr == 8'h00;
	wire wrCause = take && wbWe && wbSel[0] && wbAdr == 8'h04;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_read_data: assert property (rdNmi |=> wbAck && wbDatOut[1:0] == $past(nmiSourceFlags))
		else $error("NMI read data wrong");
	a_read_clears: assert property (rdNmi && !wdtNmiReq |=> !nmiSourceFlags[0])
		else $error("NMI flag not cleared");
	a_wdt_nmi: assert property (clkEn && wdtNmiReq |=> nmiSourceFlags[0] ##[0:1] nmiRequest)
		else $error("watchdog NMI lost");
	a_wdt_cause: assert property (clkEn && wdtResetReq |=> resetCauseFlags[2])
		else $error("watchdog cause lost");
	a_cpu_cause: assert property (clkEn && cpuSysResetReq |=> resetCauseFlags[4])
		else $error("CPU cause lost");
	a_cause_clear: assert property (wrCause && !wbDatIn[0] |=> !resetCauseFlags[0])
		else $error("pin flag not cleared");
	a_pin_sticky: assert property (nmiSourceFlags[1] && !rdNmi |=> nmiSourceFlags[1])
		else $error("pin NMI flag lost");
	a_upper_zero: assert property (wbAck && wbAdr == 8'h04 |-> wbDatOut[31:5] == 27'h0)
		else $error("cause upper bits set");
	a_pin_init: assert property ($rose(rst_n) |-> resetCauseFlags == 5'h01)
		else $error("cause flags wrong after reset");
	c_read: cover property (rdNmi);
	c_nmi: cover property (clkEn && wdtNmiReq);
	c_clear: cover property (wrCause);
endmodule
bind nmi_and_reset_cause_flags flags_monitor #(.ADR_WIDTH(ADR_WIDTH)) mon (.core_clk(core_clk),
	.rst_n(rst_n), .clkEn(clkEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
	.wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .wdtNmiReq(wdtNmiReq),
	.wdtResetReq(wdtResetReq), .cpuSysResetReq(cpuSysResetReq), .nmiRequest(nmiRequest),
	.nmiSourceFlags(nmiSourceFlags), .resetCauseFlags(resetCauseFlags));
`default_nettype wire

// ==== tb/nmi_and_reset_cause_flags_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module nmi_and_reset_cause_flags_test;
	logic core_clk, rst_n, clkEn, wbCyc, wbStb, wbWe, wbAck, irq;
	logic nmiPin, wdtNmiReq, wdtResetReq, cpuSysResetReq, nmiRequest;
	logic [1:0] nmiSourceFlags;
	logic [4:0] resetCauseFlags;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatIn, wbDatOut, rdData;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	nmi_and_reset_cause_flags dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .nmiPin(nmiPin),
		.wdtNmiReq(wdtNmiReq), .wdtResetReq(wdtResetReq), .cpuSysResetReq(cpuSysResetReq),
		.nmiRequest(nmiRequest), .nmiSourceFlags(nmiSourceFlags),
		.resetCauseFlags(resetCauseFlags), .irq(irq));
	event_sources src (.core_clk(core_clk), .nmiPin(nmiPin), .wdtNmiReq(wdtNmiReq),
		.wdtResetReq(wdtResetReq), .cpuSysResetReq(cpuSysResetReq));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic give_verdict();
		$display("Checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d,
		input logic [3:0] s);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= s;
		wbDatIn <= d;
		@(posedge core_clk);
		while (wbAck !== 1'b1)
			@(posedge core_clk);
		rdData = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0, 4'hF);
		check($sformatf("reg %h", a), exp, rdData);
	endtask
	task automatic done(input string t);
		$display("Test %s finished", t);
	endtask
	initial
	begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 8'h00;
		wbSel = 4'hF;
		wbDatIn = 32'h0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(8'h04, 32'h00000001);
		rd(8'h00, 32'h00000000);
		rd(8'h10, 32'h00000000);
		done("reset");
		src.fire(0);
		@(posedge core_clk);
		check("nmiRequest", 32'h1, {31'h0, nmiRequest});
		check("nmiSourceFlags", 32'h1, {30'h0, nmiSourceFlags});
		src.fire(0);
		rd(8'h00, 32'h00000001);
		rd(8'h00, 32'h00000000);
		check("nmiSourceFlags", 32'h0, {30'h0, nmiSourceFlags});
		check("nmiRequest", 32'h0, {31'h0, nmiRequest});
		src.pin(1'b1);
		repeat (5) @(posedge core_clk);
		rd(8'h00, 32'h00000002);
		src.pin(1'b0);
		done("nmi");
		src.fire(1);
		src.fire(2);
		rd(8'h04, 32'h00000015);
		check("resetCauseFlags", 32'h15, {27'h0, resetCauseFlags});
		bus(8'h04, 1'b1, 32'h00000015, 4'hF);
		rd(8'h04, 32'h00000015);
		bus(8'h04, 1'b1, 32'h00000014, 4'hF);
		rd(8'h04, 32'h00000014);
		bus(8'h04, 1'b1, 32'h00000000, 4'hE);
		rd(8'h04, 32'h00000014);
		done("cause");
		bus(8'h08, 1'b1, 32'h0000000F, 4'hF);
		bus(8'h0C, 1'b1, 32'h00000001, 4'hF);
		src.fire(1);
		src.fire(0);
		repeat (2) @(posedge core_clk);
		check("irq", 32'h1, {31'h0, irq});
		rd(8'h08, 32'h00000005);
		bus(8'h08, 1'b1, 32'h00000001, 4'hF);
		check("irq", 32'h0, {31'h0, irq});
		done("irq");
		src.fire(2);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(8'h04, 32'h00000001);
		rd(8'h0C, 32'h00000000);
		check("resetCauseFlags", 32'h1, {27'h0, resetCauseFlags});
		done("second reset");
		clkEn <= 1'b0;
		src.fire(0);
		fork
			rd(8'h00, 32'h00000000);
			begin
				repeat (3) @(posedge core_clk);
				clkEn <= 1'b1;
			end
		join
		check("nmiSourceFlags", 32'h0, {30'h0, nmiSourceFlags});
		done("freeze");
		give_verdict();
	end
endmodule
`default_nettype wire
